// file: rtl/shreg_params.svh
// constants for the indexed shift register function block
// Overview of operation
// RQ1: shift only on strobe rising edge
// RQ2: strobe falling edge changes nothing
// RQ3: serial input sampled when shift starts
// RQ4: direction 0 shifts stage 1 toward 8
// RQ5: direction 1 shifts stage 8 toward 1
// RQ6: clear edge zeroes stages and output
// RQ7: four instances chosen by index 1-4; the code selects them with index values 0-3
// RQ8: output follows configured stage 1-8
// RQ9: retentive setting keeps stages over restart
// RQ10: stages addressed by instance and position
// RQ11: up shift: stage 1 takes input
// RQ12: down shift: stage 8 takes input
// RQ13: non-retentive stages lost on power failure
// RQ14: edges from previous cycle, one shift
// RQ15: clear beats shift in same cycle
`ifndef SHREG_PARAMS_SVH
`define SHREG_PARAMS_SVH

`define ADDR_CTRL      12'h000
`define ADDR_STATUS    12'h004

`define CTRL_IDX_LSB   0
`define CTRL_IDX_MSB   1
`define CTRL_BIT_LSB   4
`define CTRL_BIT_MSB   6
`define CTRL_RETAIN    8
`define CTRL_RESET     9'h000

`define STAT_Q         8
`define STAT_INIT      9
`define STAT_LVL_LSB   16
`define STAT_LVL_MSB   21

`define NUM_INST       4
`define NUM_STAGES     8
`define FIFO_DEPTH     32

`define CLK_PERIOD_NS  10
`define PROG_CYCLE_NS  1000
`define PROG_CYCLE_CNT ((`PROG_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: rtl/shreg_pkg.sv
// types shared by the shift register function block
package shreg_pkg;

  typedef struct packed {
    logic [1:0] idx;
    logic       clear;
    logic       shift;
    logic       dir;
    logic       din;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_UPD  = 3'b100
  } eng_state_t;

endpackage : shreg_pkg

// file: rtl/shreg_fifo.sv
// command fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module shreg_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 32
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  wire              do_push = in_valid && in_ready;
  wire              do_pop  = out_valid && out_ready;

  assign level     = wptr - rptr;
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = store[rptr[AW-1:0]];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (do_push) wptr <= wptr + 1'b1;
      if (do_pop) rptr <= rptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_push) store[wptr[AW-1:0]] <= in_data;
  end

  a_fifo_bounds: assert property (@(posedge sys_clk) disable iff (!rstn)
    level <= (AW+1)'(DEPTH)) else $error("fifo level beyond depth");
endmodule : shreg_fifo
`default_nettype wire

// file: rtl/shreg_stage_mem.sv
// stage memory, one word per instance, registered read
`timescale 1ns/1ps
`default_nettype none
module shreg_stage_mem #(
  parameter int AW = 2,
  parameter int DW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic [DW-1:0]      rdata
);
  // array has no reset so contents can outlive a soft restart
  logic [DW-1:0] words [2**AW];

  always_ff @(posedge sys_clk) begin
    if (we) words[waddr] <= wdata;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rdata <= '0;
    else rdata <= words[raddr];
  end
endmodule : shreg_stage_mem
`default_nettype wire

// file: rtl/shreg_block.sv
// indexed eight-stage shift register function block with apb control
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "shreg_params.svh"
module shreg_block
  import shreg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // function block inputs
  input  wire logic        din,
  input  wire logic        trg,
  input  wire logic        dir,
  input  wire logic        clr,
  input  wire logic        restart,
  // function block output
  output logic             q
);

  // ---------------- apb register file ----------------
  logic [8:0]  ctrl;
  logic [1:0]  cfg_idx;
  logic [2:0]  cfg_bit;
  logic        cfg_retain;
  logic [7:0]  stages;
  logic [5:0]  fifo_level;
  eng_state_t  st;

  wire         hit_ctrl   = (paddr == `ADDR_CTRL);
  wire         hit_status = (paddr == `ADDR_STATUS);
  wire         acc        = psel && penable;
  wire         setup      = psel && !penable;
  wire         wr_ctrl    = acc && pwrite && hit_ctrl;
  wire         bad_addr   = !(hit_ctrl || hit_status);
  wire         bad_write  = pwrite && hit_status;
  wire [31:0]  rd_ctrl    = {23'h0, ctrl};
  wire [31:0]  rd_status;
  wire [31:0]  rd_mux;

  assign rd_status = {10'h0, fifo_level, 6'h0, (st == ST_INIT), q, stages};
  assign rd_mux    = hit_ctrl ? rd_ctrl : (hit_status ? rd_status : 32'h0);
  assign pready    = 1'b1;
  assign pslverr   = acc && (bad_addr || bad_write);

  assign cfg_idx    = ctrl[`CTRL_IDX_MSB:`CTRL_IDX_LSB];
  assign cfg_bit    = ctrl[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
  assign cfg_retain = ctrl[`CTRL_RETAIN];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      if (pstrb[0]) ctrl[7:0] <= pwdata[7:0];
      if (pstrb[1]) ctrl[`CTRL_RETAIN] <= pwdata[`CTRL_RETAIN];
    end
  end

  // read data captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) prdata <= 32'h0;
    else if (setup && !pwrite) prdata <= rd_mux;
  end

  // ---------------- program cycle divider ----------------
  logic [6:0] div_cnt;
  logic       tick_due;
  wire        div_wrap = (div_cnt == 7'(`PROG_CYCLE_CNT - 1));
  logic       fifo_in_ready;
  wire        push = tick_due && fifo_in_ready;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) div_cnt <= '0;
    else div_cnt <= div_wrap ? 7'h00 : div_cnt + 7'h01;
  end

  // a full fifo holds the program cycle back rather than dropping it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tick_due <= 1'b0;
    else tick_due <= div_wrap || (tick_due && !push);
  end

  // ---------------- edge detection per program cycle ----------------
  logic trg_prev;
  logic clr_prev;
  cmd_t push_cmd;

  assign push_cmd.idx   = cfg_idx;                 // [RQ7] [RQ10]
  assign push_cmd.clear = clr && !clr_prev;        // [RQ6] [RQ14]
  assign push_cmd.shift = trg && !trg_prev;        // [RQ1] [RQ2] [RQ14]
  assign push_cmd.dir   = dir;
  assign push_cmd.din   = din;                     // [RQ3]

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trg_prev <= 1'b0;
      clr_prev <= 1'b0;
    end else if (push) begin
      trg_prev <= trg;
      clr_prev <= clr;
    end
  end

  // ---------------- command fifo ----------------
  cmd_t fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;

  shreg_fifo #(
    .WIDTH ($bits(cmd_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (tick_due),
    .in_ready  (fifo_in_ready),
    .in_data   (push_cmd),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  // ---------------- update engine ----------------
  eng_state_t next_st;
  cmd_t       cmd;
  logic [1:0] sweep_cnt;
  logic       sweep_req;
  logic [7:0] mem_rdata;
  logic [7:0] new_stages;
  logic [7:0] shifted;

  wire        pop       = (st == ST_IDLE) && !sweep_req && fifo_out_valid;
  wire        sweep_set = restart && !cfg_retain;  // [RQ9] [RQ13]
  wire        sweep_go  = (st == ST_IDLE) && sweep_req;
  wire        sweep_end = (sweep_cnt == 2'(`NUM_INST - 1));
  wire        mem_we    = (st == ST_INIT) || (st == ST_UPD);
  wire [1:0]  mem_waddr = (st == ST_INIT) ? sweep_cnt : cmd.idx;  // [RQ10]
  wire [7:0]  mem_wdata = (st == ST_INIT) ? 8'h00 : new_stages;
  wire        cur_inst  = (cmd.idx == cfg_idx);

  assign fifo_out_ready = pop;

  // bit k holds stage k+1
  assign shifted = cmd.dir ? {cmd.din, mem_rdata[7:1]}  // [RQ5] [RQ12]
                           : {mem_rdata[6:0], cmd.din}; // [RQ4] [RQ11]
  assign new_stages = cmd.clear ? 8'h00                  // [RQ6] [RQ15]
                    : (cmd.shift ? shifted : mem_rdata);

  shreg_stage_mem #(
    .AW (2),
    .DW (`NUM_STAGES)
  ) u_mem (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (fifo_out.idx),
    .rdata   (mem_rdata)
  );

  always_comb begin
    next_st = st;
    case (st)
      ST_INIT: begin
        if (sweep_end) next_st = ST_IDLE;
      end
      ST_IDLE: begin
        if (sweep_req) next_st = ST_INIT;
        else if (fifo_out_valid) next_st = ST_UPD;
      end
      ST_UPD: begin
        next_st = ST_IDLE;
      end
      default: begin
        next_st = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) st <= ST_INIT;
    else st <= next_st;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) sweep_cnt <= 2'b00;
    else if (st == ST_INIT) sweep_cnt <= sweep_cnt + 2'b01;
    else sweep_cnt <= 2'b00;
  end

  // a restart landing on the take-over cycle still wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) sweep_req <= 1'b0;
    else sweep_req <= sweep_set || (sweep_req && !sweep_go);  // [RQ13]
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) cmd <= '0;
    else if (pop) cmd <= fifo_out;
  end

  // mirror of the selected instance, refreshed every program cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) stages <= 8'h00;
    else if (st == ST_INIT) stages <= 8'h00;
    else if ((st == ST_UPD) && cur_inst) stages <= new_stages;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) q <= 1'b0;
    else q <= stages[cfg_bit];  // [RQ8]
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_rise_gives_shift: assert property (  // [RQ1]
    push && trg && !trg_prev |-> push_cmd.shift)
    else $error("trigger rise without shift");

  a_fall_no_shift: assert property (  // [RQ2]
    push && trg_prev && !trg |-> !push_cmd.shift ##1 !trg_prev)
    else $error("trigger fall caused a shift");

  a_sample_input: assert property (  // [RQ3]
    pop && fifo_out.shift |=> cmd.din == $past(fifo_out.din))
    else $error("sampled input lost");

  a_shift_up: assert property (  // [RQ4] [RQ11]
    st == ST_UPD && cmd.shift && !cmd.clear && !cmd.dir
    |-> mem_we && mem_wdata == {mem_rdata[6:0], cmd.din} && mem_waddr == cmd.idx)
    else $error("upward shift wrong");

  a_shift_down: assert property (  // [RQ5] [RQ12]
    st == ST_UPD && cmd.shift && !cmd.clear && cmd.dir
    |-> mem_wdata[7] == cmd.din && mem_wdata[6:0] == mem_rdata[7:1])
    else $error("downward shift wrong");

  a_clear_wins: assert property (  // [RQ6] [RQ15]
    st == ST_UPD && cmd.clear && cur_inst && $stable(cfg_bit)
    |=> stages == 8'h00 ##1 !q)
    else $error("clear did not zero stages and output");

  a_index_carried: assert property (  // [RQ7] [RQ10]
    push |-> push_cmd.idx == cfg_idx ##1 (fifo_level != 6'h00 || st == ST_UPD))
    else $error("command not queued for selected instance");

  a_output_tracks: assert property (  // [RQ8]
    $stable(cfg_bit) |=> q == $past(stages[cfg_bit]))
    else $error("output does not follow stage");

  a_retain_keeps: assert property (  // [RQ9]
    restart && cfg_retain && !sweep_req && st != ST_INIT |=> !sweep_req)
    else $error("retentive restart cleared stages");

  a_lost_on_fail: assert property (  // [RQ13]
    restart && !cfg_retain |=> ##[0:2] st == ST_INIT)
    else $error("non-retentive restart kept stages");

  a_one_per_cycle: assert property (  // [RQ14]
    push |=> !push ##1 !push)
    else $error("more than one program cycle taken");

  // zero wait states, so every access is judged in its own cycle
  a_bad_addr_err: assert property (
    acc && bad_addr |-> pslverr)
    else $error("unmapped access not flagged");

  a_status_ro: assert property (
    acc && pwrite && hit_status |-> pslverr ##1 $stable(ctrl))
    else $error("status write not refused");

  a_slverr_only_acc: assert property (
    !acc |-> !pslverr)
    else $error("error flag outside access phase");

  a_read_data_holds: assert property (
    !(setup && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  a_unmapped_zero: assert property (
    setup && !pwrite && bad_addr |=> prdata == 32'h0)
    else $error("unmapped read returned data");

  a_ctrl_index: assert property (  // [RQ7]
    wr_ctrl && pstrb[0] |=> cfg_idx == $past(pwdata[`CTRL_IDX_MSB:`CTRL_IDX_LSB]))
    else $error("instance index not written");

  a_ctrl_retain: assert property (  // [RQ9]
    wr_ctrl && pstrb[1] |=> cfg_retain == $past(pwdata[`CTRL_RETAIN]))
    else $error("retain setting not written");

  // sweep takes four cycles, one per instance
  a_sweep_zeroes: assert property (  // [RQ13]
    st == ST_INIT |-> mem_we && mem_wdata == 8'h00 && mem_waddr == sweep_cnt)
    else $error("sweep did not zero the instance");

  a_sweep_length: assert property (  // [RQ13]
    $rose(st == ST_INIT) |-> st == ST_INIT [*4] ##1 st == ST_IDLE)
    else $error("sweep did not cover all instances");

  a_sweep_mirror: assert property (  // [RQ13]
    st == ST_INIT |=> stages == 8'h00)
    else $error("mirror kept data through sweep");

  a_no_edge_keeps: assert property (  // [RQ1] [RQ2]
    st == ST_UPD && !cmd.shift && !cmd.clear |-> mem_wdata == mem_rdata)
    else $error("stages changed without an edge");

  a_clear_memory: assert property (  // [RQ6] [RQ15]
    st == ST_UPD && cmd.clear |-> mem_we && mem_wdata == 8'h00)
    else $error("clear did not reach stage memory");

  a_update_slot: assert property (  // [RQ14]
    pop |=> st == ST_UPD ##1 st == ST_IDLE)
    else $error("command not applied in one update");

  a_update_address: assert property (  // [RQ10]
    st == ST_UPD |-> mem_waddr == cmd.idx)
    else $error("update written to wrong instance");

  a_other_inst_kept: assert property (  // [RQ10]
    st == ST_UPD && !cur_inst |=> $stable(stages))
    else $error("mirror changed by another instance");

  c_shift_up:   cover property (st == ST_UPD && cmd.shift && !cmd.dir && !cmd.clear);
  c_shift_down: cover property (st == ST_UPD && cmd.shift && cmd.dir && !cmd.clear);
  c_clear_both: cover property (st == ST_UPD && cmd.shift && cmd.clear);
  c_fifo_full:  cover property (!fifo_in_ready && tick_due);
  c_restart_sweep: cover property (restart && !cfg_retain && st == ST_IDLE);

endmodule : shreg_block
`default_nettype wire

// file: tb/shreg_peer.sv
// neighbouring logic blocks that drive the function block inputs
`timescale 1ns/1ps
`default_nettype none
module shreg_peer #(
  parameter int HOLD = 150
) (
  input  wire logic sys_clk,
  output logic      din,
  output logic      trg,
  output logic      dir,
  output logic      clr
);
  initial begin
    din = 1'b0;
    trg = 1'b0;
    dir = 1'b0;
    clr = 1'b0;
  end
  // each level stands longer than one program cycle so that no edge is missed
  task automatic pulse(input logic d, input logic dr, input logic c, input logic t);
    din <= d;
    dir <= dr;
    trg <= 1'b0;
    clr <= 1'b0;
    repeat (HOLD) @(posedge sys_clk);
    trg <= t;
    clr <= c;
    repeat (HOLD) @(posedge sys_clk);
  endtask : pulse
endmodule : shreg_peer
`default_nettype wire

// file: tb/indexed_shift_register_test.sv
// self-checking bench for the shift register function block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module indexed_shift_register_test;
  logic        sys_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        din;
  logic        trg;
  logic        dir;
  logic        clr;
  logic        restart;
  logic        q;
  logic [7:0]  exp_st [4];
  logic [31:0] rd;
  logic        err;
  int          cur;
  int          bsel;
  int          error_cnt;
  int          cmp_count;

  shreg_block u_shreg_block (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .trg(trg), .dir(dir), .clr(clr), .restart(restart), .q(q));
  shreg_peer u_shreg_peer (.sys_clk(sys_clk), .din(din), .trg(trg), .dir(dir), .clr(clr));

  always #5 sys_clk = ~sys_clk;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
  endtask : apb

  // index change only reaches the mirror at the next program cycle, hence the long wait
  task automatic cfg(input int i, input int b, input logic ret);
    cur  = i;
    bsel = b;
    apb(1'b1, 12'h000, {23'h0, ret, 1'b0, 3'(b), 2'b0, 2'(i)}, 4'h3);
    repeat (210) @(posedge sys_clk);
  endtask : cfg

  task automatic shift(input logic d, input logic dr);
    exp_st[cur] = dr ? {d, exp_st[cur][7:1]} : {exp_st[cur][6:0], d};
    u_shreg_peer.pulse(d, dr, 1'b0, 1'b1);
  endtask : shift

  task automatic chk_state;
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    `CHK(rd[7:0], exp_st[cur])
    `CHK(q, exp_st[cur][bsel])
    `CHK({rd[31:22], rd[15:8]}, {17'h0, exp_st[cur][bsel]})
  endtask : chk_state

  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hF);
    `CHK(err, 1'b1)
    chk_state();
    $display("test regs done");
  endtask : t_regs

  task automatic t_up;
    cfg(0, 0, 1'b0);
    shift(1'b1, 1'b0);
    shift(1'b0, 1'b0);
    shift(1'b1, 1'b0);
    shift(1'b1, 1'b0);
    for (int b = 0; b < 8; b++) begin
      cfg(0, b, 1'b0);
      chk_state();
    end
    $display("test up done");
  endtask : t_up

  task automatic t_down;
    shift(1'b1, 1'b1);
    shift(1'b0, 1'b1);
    chk_state();
    $display("test down done");
  endtask : t_down

  task automatic t_hold;
    shift(1'b0, 1'b0);
    repeat (300) @(posedge sys_clk);
    chk_state();
    u_shreg_peer.pulse(1'b1, 1'b0, 1'b0, 1'b0);
    chk_state();
    $display("test hold done");
  endtask : t_hold

  task automatic t_index;
    cfg(1, 7, 1'b0);
    chk_state();
    shift(1'b1, 1'b0);
    shift(1'b1, 1'b1);
    chk_state();
    cfg(3, 7, 1'b0);
    shift(1'b1, 1'b1);
    chk_state();
    cfg(0, 2, 1'b0);
    chk_state();
    $display("test index done");
  endtask : t_index

  task automatic t_clear;
    exp_st[cur] = 8'h00;
    u_shreg_peer.pulse(1'b1, 1'b0, 1'b1, 1'b1);
    chk_state();
    shift(1'b1, 1'b0);
    chk_state();
    $display("test clear done");
  endtask : t_clear

  // power return: only the retain bit decides whether the stages survive
  task automatic t_retain;
    cfg(0, 0, 1'b1);
    restart <= 1'b1;
    @(posedge sys_clk);
    restart <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk_state();
    cfg(0, 0, 1'b0);
    restart <= 1'b1;
    @(posedge sys_clk);
    restart <= 1'b0;
    repeat (20) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) exp_st[i] = 8'h00;
    chk_state();
    $display("test retain done");
  endtask : t_retain

  initial begin
    sys_clk   = 1'b0;
    rstn      = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    pstrb     = 4'h0;
    restart   = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cur       = 0;
    bsel      = 0;
    for (int i = 0; i < 4; i++) exp_st[i] = 8'h00;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_regs();
    t_up();
    t_down();
    t_hold();
    t_index();
    t_clear();
    t_retain();
    finish_test();
  end
endmodule : indexed_shift_register_test
`default_nettype wire
